// *** logic/bridge_route.sv ***
// address decode and routing of the virtual bridge, with its config registers
`timescale 1ns/1ns
module bridge_route
  import bridge_route_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // byte-wide configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // windows and controls owned elsewhere
  input wire logic [WIN_W-1:0] nonprefetch_window_base_i,
  input wire logic [WIN_W-1:0] nonprefetch_window_limit_i,
  input wire logic [15:0] io_window_base_i,
  input wire logic [15:0] io_window_limit_i,
  input wire logic mono_adapter_routing_i,
  // cpu request and routing decision
  input wire bridge_route_pkg::cpu_req_t cpu_req_i,
  output bridge_route_pkg::route_t route_o,
  // completion of a secondary bus cycle
  input wire logic sec_done_i,
  input wire logic sec_is_read_i,
  input wire logic sec_master_abort_i,
  input wire logic [31:0] sec_rdata_i,
  output logic cmpl_valid_o,
  output logic [31:0] cmpl_rdata_o,
  output logic wr_discard_o,
  output logic abort_error_o
);
  import bridge_route_pkg::*;

  logic [15:0] pref_base_r;
  logic [15:0] pref_limit_r;
  logic [7:0] bridge_control_r;
  logic [7:0] cfg_rdata_r;
  route_t route_r;
  logic cmpl_valid_r;
  logic [31:0] cmpl_rdata_r;
  logic wr_discard_r;
  logic abort_error_r;

  // control bits
  wire logic master_abort_mode = bridge_control_r[MASTER_ABORT_MODE_BIT];
  wire logic vga_forward_enable = bridge_control_r[VGA_FORWARD_BIT];
  wire logic isa_alias_filter = bridge_control_r[ISA_FILTER_BIT];
  // reserved combination of vga clear with mono set acts as both clear
  wire logic mono_route = vga_forward_enable & mono_adapter_routing_i;

  // config write strobes
  wire logic wr_en = ce_i & cfg_wr_i;
  wire logic wr_base_lo = wr_en && (cfg_addr_i == PREF_BASE_LO_OFF);
  wire logic wr_base_hi = wr_en && (cfg_addr_i == PREF_BASE_HI_OFF);
  wire logic wr_limit_lo = wr_en && (cfg_addr_i == PREF_LIMIT_LO_OFF);
  wire logic wr_limit_hi = wr_en && (cfg_addr_i == PREF_LIMIT_HI_OFF);
  wire logic wr_bridge_control = wr_en && (cfg_addr_i == BRIDGE_CTRL_OFF);

  // next register values, window low nibbles forced to zero, bridge control masked by BRIDGE_CTRL_WR_MASK
  wire logic [15:0] base_nxt =
    {wr_base_hi ? cfg_wdata_i : pref_base_r[15:8],
     wr_base_lo ? cfg_wdata_i : pref_base_r[7:0]} & ~WIN_RO_MASK;
  wire logic [15:0] limit_nxt =
    {wr_limit_hi ? cfg_wdata_i : pref_limit_r[15:8],
     wr_limit_lo ? cfg_wdata_i : pref_limit_r[7:0]} & ~WIN_RO_MASK;
  wire logic [7:0] bridge_control_nxt = cfg_wdata_i & BRIDGE_CTRL_WR_MASK;

  // config read decode, unmapped offsets read zero
  logic [7:0] rd_sel;
  always_comb begin
    if (cfg_addr_i == PREF_BASE_LO_OFF) begin
      rd_sel = pref_base_r[7:0];
    end else if (cfg_addr_i == PREF_BASE_HI_OFF) begin
      rd_sel = pref_base_r[15:8];
    end else if (cfg_addr_i == PREF_LIMIT_LO_OFF) begin
      rd_sel = pref_limit_r[7:0];
    end else if (cfg_addr_i == PREF_LIMIT_HI_OFF) begin
      rd_sel = pref_limit_r[15:8];
    end else if (cfg_addr_i == BRIDGE_CTRL_OFF) begin
      rd_sel = bridge_control_r;
    end else begin
      rd_sel = 8'h00;
    end
  end

  // window comparators: prefetchable and non-prefetchable
  wire logic [WIN_W-1:0] win_base [NUM_WIN];
  wire logic [WIN_W-1:0] win_limit [NUM_WIN];
  wire logic [NUM_WIN-1:0] win_hit;
  assign win_base[0] = pref_base_r[15:WIN_FIELD_LSB];
  assign win_limit[0] = pref_limit_r[15:WIN_FIELD_LSB];
  assign win_base[1] = nonprefetch_window_base_i;
  assign win_limit[1] = nonprefetch_window_limit_i;

  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_win
      mb_window_match u_match (
        .base_i(win_base[g]),
        .limit_i(win_limit[g]),
        .addr_i(cpu_req_i.addr),
        .hit_o(win_hit[g])
      );
    end
  endgenerate

  // legacy video decode
  wire logic [31:0] a = cpu_req_i.addr;
  wire logic [9:0] a10 = a[9:0];
  wire logic vga_mem = (a[31:17] == VGA_MEM_TAG);
  wire logic mda_mem = (a[31:15] == MDA_MEM_TAG);
  wire logic vga_io = ((a10 >= VGA_IO_A_LO) && (a10 <= VGA_IO_A_HI)) ||
                      ((a10 >= VGA_IO_B_LO) && (a10 <= VGA_IO_B_HI));
  wire logic mda_excl = (a10 >= MDA_EXCL_LO) && (a10 <= MDA_EXCL_HI);
  wire logic mda_io = (a10 >= VGA_IO_A_LO) && (a10 <= MDA_EXCL_HI);

  // ordinary io window with isa alias filter
  wire logic io_in_win = (a[15:0] >= io_window_base_i) && (a[15:0] <= io_window_limit_i);
  wire logic isa_alias = isa_alias_filter && (a[9:8] != 2'b00);
  wire logic io_win_fwd = io_in_win && !isa_alias;

  // routing choice
  target_t tgt;
  always_comb begin
    tgt = TGT_HUB;
    if (cpu_req_i.is_io) begin
      if (vga_forward_enable && (mda_excl || (mono_route && mda_io))) begin
        tgt = TGT_HUB;
      end else if (vga_forward_enable && vga_io) begin
        tgt = TGT_SEC_VGA;
      end else if (io_win_fwd) begin
        tgt = TGT_SEC_WINDOW;
      end
    end else begin
      if (mono_route && mda_mem) begin
        tgt = TGT_HUB;
      end else if (vga_forward_enable && vga_mem) begin
        tgt = TGT_SEC_VGA;
      end else if (|win_hit) begin
        tgt = TGT_SEC_WINDOW;
      end
    end
  end

  // completion handling of secondary bus cycles
  wire logic aborted = sec_done_i & sec_master_abort_i;
  wire logic [31:0] cmpl_data_nxt =
    (aborted && master_abort_mode) ? ABORT_READ_DATA : sec_rdata_i;

  // registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pref_base_r <= PREF_BASE_RST;
      pref_limit_r <= PREF_LIMIT_RST;
      bridge_control_r <= BRIDGE_CTRL_RST;
    end else if (ce_i) begin
      pref_base_r <= base_nxt;
      pref_limit_r <= limit_nxt;
      if (wr_bridge_control) begin
        bridge_control_r <= bridge_control_nxt;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_rdata_r <= 8'h00;
      route_r <= '0;
    end else if (ce_i) begin
      if (cfg_rd_i) begin
        cfg_rdata_r <= rd_sel;
      end
      route_r.valid <= cpu_req_i.valid;
      route_r.to_secondary <= cpu_req_i.valid && (tgt != TGT_HUB);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmpl_valid_r <= 1'b0;
      cmpl_rdata_r <= 32'h00000000;
      wr_discard_r <= 1'b0;
      abort_error_r <= 1'b0;
    end else if (ce_i) begin
      cmpl_valid_r <= sec_done_i & sec_is_read_i;
      if (sec_done_i && sec_is_read_i) begin
        cmpl_rdata_r <= cmpl_data_nxt;
      end
      wr_discard_r <= aborted && master_abort_mode && !sec_is_read_i;
      abort_error_r <= aborted && !master_abort_mode;
    end
  end

  assign cfg_rdata_o = cfg_rdata_r;
  assign route_o = route_r;
  assign cmpl_valid_o = cmpl_valid_r;
  assign cmpl_rdata_o = cmpl_rdata_r;
  assign wr_discard_o = wr_discard_r;
  assign abort_error_o = abort_error_r;

  // checks
  a_reserved_low_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (pref_base_r[3:0] == 4'h0) && (pref_limit_r[3:0] == 4'h0))
    else $error("window low nibble not zero");

  a_base_write_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && wr_base_hi) |=> (pref_base_r[15:8] == $past(cfg_wdata_i)))
    else $error("base high byte write lost");

  a_pref_hit_route: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && cpu_req_i.valid && !cpu_req_i.is_io &&
     (a[31:20] >= pref_base_r[15:4]) && (a[31:20] <= pref_limit_r[15:4]) &&
     !(mono_route && mda_mem)) |=> route_o.to_secondary)
    else $error("prefetch window hit not forwarded");

  a_empty_window: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (pref_base_r[15:4] > pref_limit_r[15:4]) |-> !win_hit[0])
    else $error("inverted window produced a hit");

  a_abort_ones: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && aborted && sec_is_read_i && master_abort_mode) |=>
    (cmpl_valid_o && cmpl_rdata_o == ABORT_READ_DATA))
    else $error("aborted read did not return all ones");

  a_abort_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && aborted && !sec_is_read_i && master_abort_mode) |=> wr_discard_o && !abort_error_o)
    else $error("aborted write not discarded");

  a_vga_mem_fwd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && cpu_req_i.valid && !cpu_req_i.is_io && vga_forward_enable && vga_mem &&
     !(mono_route && mda_mem)) |=> route_o.to_secondary)
    else $error("vga memory not forwarded");

  a_vga_io_fwd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && cpu_req_i.valid && cpu_req_i.is_io && vga_forward_enable && vga_io &&
     !mono_route) |=> route_o.to_secondary)
    else $error("vga io not forwarded");

  a_mda_excl_hub: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && cpu_req_i.valid && cpu_req_i.is_io && vga_forward_enable && mda_excl) |=>
    route_o.valid && !route_o.to_secondary)
    else $error("mono exclusive io left the hub");

  a_isa_alias_hub: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && cpu_req_i.valid && cpu_req_i.is_io && !vga_forward_enable &&
     isa_alias_filter && a[9:8] != 2'b00) |=> !route_o.to_secondary)
    else $error("isa alias forwarded to secondary");

  a_no_vga_hub: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && cpu_req_i.valid && !cpu_req_i.is_io && !vga_forward_enable && vga_mem &&
     win_hit == '0) |=> !route_o.to_secondary)
    else $error("legacy memory forwarded without vga");
endmodule : bridge_route

// *** common/bridge_route_pkg.sv ***
// shared constants and types for the bridge routing block
package bridge_route_pkg;
  // config offsets of the byte-wide register port
  localparam logic [7:0] PREF_BASE_LO_OFF = 8'h24;
  localparam logic [7:0] PREF_BASE_HI_OFF = 8'h25;
  localparam logic [7:0] PREF_LIMIT_LO_OFF = 8'h26;
  localparam logic [7:0] PREF_LIMIT_HI_OFF = 8'h27;
  localparam logic [7:0] BRIDGE_CTRL_OFF = 8'h3E;
  // reset values
  localparam logic [15:0] PREF_BASE_RST = 16'hFFF0;
  localparam logic [15:0] PREF_LIMIT_RST = 16'h0000;
  localparam logic [7:0] BRIDGE_CTRL_RST = 8'h00;
  // field layout
  localparam int WIN_FIELD_LSB = 4;
  localparam logic [15:0] WIN_RO_MASK = 16'h000F;
  localparam logic [7:0] BRIDGE_CTRL_WR_MASK = 8'h2D;
  localparam int MASTER_ABORT_MODE_BIT = 5;
  localparam int VGA_FORWARD_BIT = 3;
  localparam int ISA_FILTER_BIT = 2;
  // window granularity: address bits below this are implied
  localparam int WIN_ADDR_LSB = 20;
  localparam int WIN_W = 12;
  // legacy video ranges
  localparam logic [14:0] VGA_MEM_TAG = 15'h0005;
  localparam logic [16:0] MDA_MEM_TAG = 17'h00016;
  localparam logic [9:0] VGA_IO_A_LO = 10'h3B0;
  localparam logic [9:0] VGA_IO_A_HI = 10'h3BB;
  localparam logic [9:0] MDA_EXCL_LO = 10'h3BC;
  localparam logic [9:0] MDA_EXCL_HI = 10'h3BF;
  localparam logic [9:0] VGA_IO_B_LO = 10'h3C0;
  localparam logic [9:0] VGA_IO_B_HI = 10'h3DF;
  localparam logic [31:0] ABORT_READ_DATA = 32'hFFFFFFFF;
  localparam int NUM_WIN = 2;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } cpu_req_t;

  typedef struct packed {
    logic valid;
    logic to_secondary;
  } route_t;

  typedef enum logic [1:0] {
    TGT_HUB = 2'b00,
    TGT_SEC_WINDOW = 2'b01,
    TGT_SEC_VGA = 2'b10
  } target_t;
endpackage : bridge_route_pkg

// *** logic/mb_window_match.sv ***
// 1 MB granular base/limit window comparator
`timescale 1ns/1ns
module mb_window_match
  import bridge_route_pkg::*;
(
  // window bounds in address bits 31:20
  input wire logic [WIN_W-1:0] base_i,
  input wire logic [WIN_W-1:0] limit_i,
  // address under test
  input wire logic [31:0] addr_i,
  // result
  output logic hit_o
);
  // low bits of base read as zeros, of limit as ones
  wire logic [31:0] lo_bound = {base_i, {WIN_ADDR_LSB{1'b0}}};
  wire logic [31:0] hi_bound = {limit_i, {WIN_ADDR_LSB{1'b1}}};
  // inclusive at both ends; base above limit never hits
  assign hit_o = (addr_i >= lo_bound) && (addr_i <= hi_bound);
endmodule : mb_window_match

// *** dv/sec_bus_model.sv ***
// secondary bus completion model for the routing bench
`timescale 1ns/1ns
module sec_bus_model (
  // clock
  input wire logic clk_i,
  // completion toward the bridge
  output logic sec_done_o,
  output logic sec_is_read_o,
  output logic sec_master_abort_o,
  output logic [31:0] sec_rdata_o
);
  initial begin
    sec_done_o = 1'b0;
    sec_is_read_o = 1'b0;
    sec_master_abort_o = 1'b0;
    sec_rdata_o = 32'h5A5A5A5A;
  end
  // one completion after idle cycles; data churns outside it
  task automatic finish(input int idle, input logic rd, input logic ab, input logic [31:0] d);
    repeat (idle) begin
      @(negedge clk_i);
      sec_rdata_o <= ~sec_rdata_o;
    end
    @(negedge clk_i);
    sec_done_o <= 1'b1;
    sec_is_read_o <= rd;
    sec_master_abort_o <= ab;
    sec_rdata_o <= d;
    @(negedge clk_i);
    sec_done_o <= 1'b0;
    sec_is_read_o <= ~rd;
    sec_master_abort_o <= ~ab;
    sec_rdata_o <= ~d;
  endtask : finish
endmodule : sec_bus_model

// *** dv/tb_bridge_route.sv ***
// self-checking bench for the bridge routing block
`timescale 1ns/1ns
module tb_bridge_route;
  import bridge_route_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic [WIN_W-1:0] np_base = 12'hFFF;
  logic [WIN_W-1:0] np_limit = 12'h000;
  logic [15:0] io_base = 16'hFFFF;
  logic [15:0] io_limit = 16'h0000;
  logic mono = 1'b0;
  logic ce = 1'b1;
  cpu_req_t req = '0;
  route_t route;
  logic [7:0] rdata;
  logic done, is_rd, mab, cmpl_v, wr_disc, ab_err;
  logic [31:0] srd, cmpl_d;
  logic [33:0] tab[$];
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #50 clk_i = ~clk_i;
  bridge_route dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(rdata), .nonprefetch_window_base_i(np_base),
    .nonprefetch_window_limit_i(np_limit), .io_window_base_i(io_base),
    .io_window_limit_i(io_limit), .mono_adapter_routing_i(mono), .cpu_req_i(req),
    .route_o(route), .sec_done_i(done), .sec_is_read_i(is_rd), .sec_master_abort_i(mab),
    .sec_rdata_i(srd), .cmpl_valid_o(cmpl_v), .cmpl_rdata_o(cmpl_d),
    .wr_discard_o(wr_disc), .abort_error_o(ab_err));
  sec_bus_model sec_u (.clk_i(clk_i), .sec_done_o(done), .sec_is_read_o(is_rd),
    .sec_master_abort_o(mab), .sec_rdata_o(srd));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    cfg_rd_i = 1'b1;
    cfg_addr_i = a;
    @(negedge clk_i);
    cfg_rd_i = 1'b0;
    cmp_byte(rdata, exp);
  endtask : cfg_rd
  // entry: bit 33 io, bit 32 expected secondary, 31:0 address
  task automatic route_all();
    foreach (tab[i]) begin
      @(negedge clk_i);
      req = {1'b1, tab[i][33], tab[i][31:0]};
      @(negedge clk_i);
      req.valid = 1'b0;
      cmp_byte({6'h00, route}, {6'h00, 1'b1, tab[i][32]});
    end
  endtask : route_all
  task automatic t_reset();
    cfg_rd(8'h24, 8'hF0);
    cfg_rd(8'h25, 8'hFF);
    cfg_rd(8'h26, 8'h00);
    cfg_rd(8'h3E, 8'h00);
    cfg_rd(8'h30, 8'h00);
    tab = '{34'h0FFF00000, 34'h000000000, 34'h000A00000};
    route_all();
    $display("reset test done");
  endtask : t_reset
  task automatic t_window();
    cfg_wr(8'h24, 8'h3F);
    cfg_wr(8'h25, 8'h12);
    cfg_wr(8'h26, 8'h4F);
    cfg_wr(8'h27, 8'h12);
    cfg_rd(8'h24, 8'h30);
    cfg_rd(8'h26, 8'h40);
    tab = '{34'h0122FFFFF, 34'h112300000, 34'h1124FFFFF, 34'h012500000, 34'h212300000};
    route_all();
    $display("window test done");
  endtask : t_window
  task automatic t_vga();
    cfg_wr(8'h3E, 8'hFF);
    cfg_rd(8'h3E, 8'h2D);
    tab = '{34'h1000A0000, 34'h1000BFFFF, 34'h00009FFFF, 34'h0000C0000, 34'h3000003B0,
      34'h3000003BB, 34'h2000003BC, 34'h2000003BF, 34'h3000003C0, 34'h3000003DF,
      34'h2000003E0, 34'h30000FFC0, 34'h20000FFBF};
    route_all();
    @(negedge clk_i);
    mono = 1'b1;
    tab = '{34'h0000B0000, 34'h2000003B4, 34'h1000A0000, 34'h3000003C0};
    route_all();
    @(negedge clk_i);
    mono = 1'b0;
    $display("vga test done");
  endtask : t_vga
  task automatic t_novga();
    cfg_wr(8'h3E, 8'h00);
    @(negedge clk_i);
    io_base = 16'h0000;
    io_limit = 16'hFFFF;
    tab = '{34'h3000003BC, 34'h3000003C0, 34'h0000A0000};
    route_all();
    cfg_wr(8'h3E, 8'h04);
    tab = '{34'h2000003BC, 34'h200000100, 34'h300000400, 34'h3000004FF, 34'h200000500};
    route_all();
    @(negedge clk_i);
    np_base = 12'h000;
    np_limit = 12'h000;
    tab = '{34'h1000A0000, 34'h000100000};
    route_all();
    $display("no vga test done");
  endtask : t_novga
  task automatic t_abort();
    cfg_wr(8'h3E, 8'h20);
    sec_u.finish(0, 1'b1, 1'b1, 32'h12345678);
    cmp_byte({5'h00, cmpl_v, wr_disc, ab_err}, 8'h04);
    cmp_word(cmpl_d, ABORT_READ_DATA);
    sec_u.finish(0, 1'b0, 1'b1, 32'h0BADF00D);
    cmp_byte({5'h00, cmpl_v, wr_disc, ab_err}, 8'h02);
    cmp_word(cmpl_d, 32'hFFFFFFFF);
    sec_u.finish(2, 1'b1, 1'b0, 32'hCAFE0001);
    cmp_word(cmpl_d, 32'hCAFE0001);
    cfg_wr(8'h3E, 8'h00);
    sec_u.finish(3, 1'b1, 1'b1, 32'h1234ABCD);
    cmp_byte({5'h00, cmpl_v, wr_disc, ab_err}, 8'h05);
    cmp_word(cmpl_d, 32'h1234ABCD);
    $display("abort test done");
  endtask : t_abort
  // enable low: a config write and a window hit must leave no trace
  task automatic t_freeze();
    @(negedge clk_i);
    ce = 1'b0;
    cfg_wr(8'h24, 8'h50);
    @(negedge clk_i);
    req = {1'b1, 1'b0, 32'h12300000};
    @(negedge clk_i);
    req.valid = 1'b0;
    cmp_byte({6'h00, route}, 8'h00);
    ce = 1'b1;
    cfg_rd(8'h24, 8'h30);
    $display("freeze test done");
  endtask : t_freeze
  initial begin
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_window();
    t_vga();
    t_novga();
    t_abort();
    t_freeze();
    give_verdict();
  end
endmodule : tb_bridge_route
